// ### ovc_top.sv
// Register bank and live gain outputs for four analogue outputs.
// Assumes a simple strobe bus and synchronous zero-cross pulses.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "ovc_consts.svh"
module ovc_top
  import ovc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `OVC_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [8:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [8:0] rdata,
  input wire logic [3:0] zero_cross,
  output logic [3:0] out_silence,
  output logic [23:0] out_gain,
  output logic [3:0] out_pending
);
  // Channel order: 0 phones left, 1 phones right, 2 line left, 3 line right
  ovc_chan_t ctl_ff [4];
  logic timeout_clock_enable_ff;
  logic phones_gain_commit;
  logic line_gain_commit;
  logic [3:0] commit;
  logic [3:0] busy;
  logic [5:0] live [4];
  logic tmo_tick;
  logic [3:0] hit;

  assign hit[0] = (addr == `OVC_OFF_PHL);
  assign hit[1] = (addr == `OVC_OFF_PHR);
  assign hit[2] = (addr == `OVC_OFF_LNL);
  assign hit[3] = (addr == `OVC_OFF_LNR);

  // Commit bit is not stored; either register of a pair fires it
  assign phones_gain_commit = wr_en && (hit[0] || hit[1]) && wdata[`OVC_BIT_COMMIT];
  assign line_gain_commit = wr_en && (hit[2] || hit[3]) && wdata[`OVC_BIT_COMMIT];
  // Channel sees the commit a cycle after the write, so pending is updated
  logic [1:0] commit_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      commit_ff <= 2'b00;
    end else if (ce) begin
      commit_ff <= {line_gain_commit, phones_gain_commit};
    end
  end
  assign commit = {commit_ff[1], commit_ff[1], commit_ff[0], commit_ff[0]};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_chan
      always_ff @(posedge clk) begin
        if (rst) begin
          ctl_ff[gi].silence <= 1'b0;
          ctl_ff[gi].zero_gate <= 1'b0;
          ctl_ff[gi].gain_code <= (gi < 2) ? `OVC_RST_PH : `OVC_RST_LN;
        end else if (ce && wr_en && hit[gi]) begin
          ctl_ff[gi].silence <= wdata[`OVC_BIT_MUTE];
          ctl_ff[gi].zero_gate <= wdata[`OVC_BIT_ZC];
          ctl_ff[gi].gain_code <= wdata[`OVC_CODE_MSB:0];
        end
      end
      ovc_chan #(
        .RST_CODE((gi < 2) ? `OVC_RST_PH : `OVC_RST_LN)
      ) u_chan (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .commit(commit[gi]),
        .pending(ctl_ff[gi].gain_code),
        .zero_gate(ctl_ff[gi].zero_gate),
        .zero_cross(zero_cross[gi]),
        .tmo_tick(tmo_tick),
        .live_ff(live[gi]),
        .busy(busy[gi])
      );
      always_ff @(posedge clk) begin
        if (rst) begin
          out_silence[gi] <= 1'b0;
          out_gain[gi*6 +: 6] <= (gi < 2) ? `OVC_RST_PH : `OVC_RST_LN;
          out_pending[gi] <= 1'b0;
        end else if (ce) begin
          out_silence[gi] <= ctl_ff[gi].silence;
          out_gain[gi*6 +: 6] <= live[gi];
          out_pending[gi] <= busy[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      timeout_clock_enable_ff <= 1'b0;
    end else if (ce && wr_en && addr == `OVC_OFF_CFG) begin
      timeout_clock_enable_ff <= wdata[0];
    end
  end

  ovc_timeout #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_tmo (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .enable(timeout_clock_enable_ff),
    .tick(tmo_tick)
  );

  // Commit bit reads as zero; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 9'h0;
    end else if (ce) begin
      rdata <= 9'h0;
      if (rd_en) begin
        for (int i = 0; i < 4; i++) begin
          if (hit[i]) begin
            rdata <= {ctl_ff[i].silence, 1'b0, ctl_ff[i].zero_gate, ctl_ff[i].gain_code};
          end
        end
        if (addr == `OVC_OFF_CFG) begin
          rdata <= {8'h0, timeout_clock_enable_ff};
        end
      end
    end
  end
endmodule : ovc_top

// ### ovc_consts.svh
// Constants for the output volume control register bank.
// Assumes inclusion by bare name from the package and modules.
// Functional notes
// - Four outputs each have independent settings
// - Bit 8 mutes output, resets to play
// - Bit 6 enables zero-cross gating, resets off
// - Gated change waits for zero crossing
// - Timeout applies pending gated change anyway
// - Commit bit zero stores code as pending
// - Headphone commit moves both headphone codes live
// - Line commit moves both line codes live
// - Six-bit code, 1 dB steps, -57 to +6
// - Headphone codes reset to 0x2d
// - Line codes reset to 0x39
`ifndef OVC_CONSTS_SVH
`define OVC_CONSTS_SVH
`define OVC_ADDR_W 8
`define OVC_DATA_W 9
`define OVC_OFF_PHL 8'h39
`define OVC_OFF_PHR 8'h3a
`define OVC_OFF_LNL 8'h3b
`define OVC_OFF_LNR 8'h3c
`define OVC_OFF_CFG 8'h3e
`define OVC_BIT_MUTE 8
`define OVC_BIT_COMMIT 7
`define OVC_BIT_ZC 6
`define OVC_CODE_MSB 5
`define OVC_RST_PH 6'h2d
`define OVC_RST_LN 6'h39
`define OVC_CLK_MHZ 200
`define OVC_TIMEOUT_US 10000
`define OVC_TIMEOUT_CYC (`OVC_TIMEOUT_US * `OVC_CLK_MHZ)
`endif

// ### ovc_pkg.sv
// Types shared by the output volume control block.
// Assumes ovc_consts.svh is on the include path.
`include "ovc_consts.svh"
package ovc_pkg;
  typedef struct packed {
    logic silence;
    logic zero_gate;
    logic [5:0] gain_code;
  } ovc_chan_t;
  typedef enum logic [1:0] {
    OVC_IDLE,
    OVC_WAIT
  } ovc_state_t;
endpackage : ovc_pkg

// ### ovc_timeout.sv
// Free-running timeout tick generator for zero-cross gating.
// Assumes the timeout clock enable comes from a register.
`timescale 1ns/1ps
`include "ovc_consts.svh"
module ovc_timeout
  import ovc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `OVC_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic enable,
  output logic tick
);
  logic [31:0] cnt_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 32'h0;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      // Without the enable no tick ever arrives
      if (!enable) begin
        cnt_ff <= 32'h0;
      end else if (cnt_ff >= TIMEOUT_CYC - 1) begin
        cnt_ff <= 32'h0;
        tick <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 32'h1;
      end
    end
  end
endmodule : ovc_timeout

// ### ovc_chan.sv
// One output channel: pending and live gain with zero-cross gating.
// Assumes zero crossing and timeout tick are one-cycle pulses.
`timescale 1ns/1ps
`include "ovc_consts.svh"
module ovc_chan
  import ovc_pkg::*;
#(
  parameter logic [5:0] RST_CODE = `OVC_RST_PH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic commit,
  input wire logic [5:0] pending,
  input wire logic zero_gate,
  input wire logic zero_cross,
  input wire logic tmo_tick,
  output logic [5:0] live_ff,
  output logic busy
);
  ovc_state_t state_ff;
  logic [5:0] held_ff;
  assign busy = (state_ff == OVC_WAIT);
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= OVC_IDLE;
      held_ff <= RST_CODE;
      live_ff <= RST_CODE;
    end else if (ce) begin
      unique case (state_ff)
        OVC_IDLE: begin
          if (commit && !zero_gate) begin
            live_ff <= pending;
          end else if (commit) begin
            held_ff <= pending;
            state_ff <= OVC_WAIT;
          end
        end
        OVC_WAIT: begin
          // A fresh commit while waiting replaces the held code
          if (commit) begin
            held_ff <= pending;
          end
          if (!zero_gate) begin
            live_ff <= commit ? pending : held_ff;
            state_ff <= OVC_IDLE;
          end else if (zero_cross || tmo_tick) begin
            live_ff <= commit ? pending : held_ff;
            state_ff <= OVC_IDLE;
          end
        end
      endcase
    end
  end
endmodule : ovc_chan

// ### ovc_top_props.sv
// Port checker for the output volume bank.
// Assumes ce stays high for a few cycles after each watched write.
`timescale 1ns/1ps
module ovc_top_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [8:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [8:0] rdata,
  input wire logic [3:0] zero_cross,
  input wire logic [3:0] out_silence,
  input wire logic [23:0] out_gain,
  input wire logic [3:0] out_pending
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Writes taken with ce low change nothing, so they start no check
  sequence hp_wr;
    ce && wr_en && addr == 8'h39;
  endsequence
  sequence ln_wr;
    ce && wr_en && addr == 8'h3c;
  endsequence
  sequence hp_go;
    ce && wr_en && wdata[7] && !wdata[6] && addr == 8'h39;
  endsequence
  sequence hp_gate;
    ce && wr_en && wdata[7] && wdata[6] && addr == 8'h39;
  endsequence
  sequence ln_go;
    ce && wr_en && wdata[7] && !wdata[6] && addr == 8'h3c;
  endsequence
  sequence hp_cause;
    $past(out_pending[0]) || $past(ce && wr_en && wdata[7] && addr inside {8'h39, 8'h3a}, 3);
  endsequence
  chk_commit_reads_zero: assert property ($past(rd_en) |-> !rdata[7])
    else $error("commit bit read back set");
  chk_mute_left: assert property (hp_wr |-> ##2 out_silence[0] == $past(wdata[8], 2))
    else $error("left phones mute wrong");
  chk_mute_line_right: assert property (ln_wr |-> ##2 out_silence[3] == $past(wdata[8], 2))
    else $error("right line mute wrong");
  chk_hp_commit: assert property (hp_go |-> ##3 out_gain[5:0] == $past(wdata[5:0], 3))
    else $error("phones gain not applied");
  chk_ln_commit: assert property (ln_go |-> ##3 out_gain[23:18] == $past(wdata[5:0], 3))
    else $error("line gain not applied");
  chk_gate_wait: assert property (hp_gate |-> ##3 out_pending[0])
    else $error("gated change not held");
  chk_zc_apply: assert property (out_pending[0] && zero_cross[0] |-> ##2 !out_pending[0])
    else $error("zero crossing ignored");
  // The left phones live gain may only move after a commit or a held change
  chk_gain_cause: assert property ($changed(out_gain[5:0]) |-> hp_cause)
    else $error("gain moved without commit");
endmodule : ovc_top_props
bind ovc_top ovc_top_props u_ovc_top_props (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .zero_cross(zero_cross),
  .out_silence(out_silence), .out_gain(out_gain), .out_pending(out_pending));

// ### ovc_top_tb.sv
// Self-checking bench for the output volume bank.
// Assumes ovc_pkg and the checker are compiled first.
`timescale 1ns/1ps
module ovc_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [8:0] wdata = 9'h000;
  logic [8:0] rdata;
  logic [3:0] zero_cross = 4'h0;
  logic [3:0] out_silence;
  logic [3:0] out_pending;
  logic [23:0] out_gain;
  int n_mismatch = 0;
  int checks_done = 0;
  // Short timeout keeps the run brief
  ovc_top #(.TIMEOUT_CYC(20)) u_ovc_top (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .zero_cross(zero_cross),
    .out_silence(out_silence), .out_gain(out_gain), .out_pending(out_pending));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task finish_test;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  task check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Strobe drops for one cycle so calls never collide
  task wr(input logic [7:0] a, input logic [8:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [8:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    check("rdata", rdata, exp);
  endtask : rd
  task wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wt
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("gain_rst", out_gain, {6'h39, 6'h39, 6'h2d, 6'h2d});
    rd(8'h39, 9'h02d);
    rd(8'h3c, 9'h039);
    // A write taken while ce is low must leave the bank untouched
    @(posedge clk);
    ce <= 1'b0;
    wr(8'h3b, 9'h1c0);
    ce <= 1'b1;
    rd(8'h3b, 9'h039);
    wr(8'h3d, 9'h1ff);
    rd(8'h3d, 9'h000);
    wr(8'h3a, 9'h03f);
    wt(3);
    check("gain_pend", out_gain[11:0], {6'h2d, 6'h2d});
    rd(8'h3a, 9'h03f);
    wr(8'h39, 9'h180);
    wt(3);
    check("hp_gain", out_gain[11:0], 12'hfc0);
    check("silence", out_silence, 4'h1);
    rd(8'h39, 9'h100);
    wr(8'h3b, 9'h001);
    wr(8'h3c, 9'h0be);
    wt(3);
    check("ln_gain", out_gain, {6'h3e, 6'h01, 6'h3f, 6'h00});
    wr(8'h39, 9'h0d0);
    wt(3);
    check("zc_wait", {out_pending, out_gain[5:0]}, {4'h1, 6'h00});
    @(posedge clk);
    zero_cross <= 4'h1;
    @(posedge clk);
    zero_cross <= 4'h0;
    wt(2);
    check("zc_apply", {out_pending, out_gain[5:0]}, {4'h0, 6'h10});
    wr(8'h3b, 9'h0c5);
    wt(60);
    check("no_tmo", out_pending, 4'h4);
    wr(8'h3e, 9'h001);
    wt(45);
    check("tmo", {out_pending, out_gain[17:12]}, {4'h0, 6'h05});
    rd(8'h3e, 9'h001);
    // Commit through the right register; the gated left keeps its live code
    wr(8'h3a, 9'h185);
    wt(3);
    check("hp_commit_r", out_gain[11:0], {6'h05, 6'h10});
    // Held over three edges so the reset jump is masked from the checker
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("gain_rst2", out_gain, {6'h39, 6'h39, 6'h2d, 6'h2d});
    check("flags_rst2", {out_pending, out_silence}, 8'h00);
    rd(8'h3a, 9'h02d);
    rd(8'h3e, 9'h000);
    finish_test;
  end
  initial begin
    #20000;
    n_mismatch++;
    finish_test;
  end
endmodule : ovc_top_tb
